//--- dac_pkg.sv
package dac_pkg;

    // ==========================================================
    // Accumulator segment widths
    // ==========================================================
    localparam int FAST_W   = 8;   // Fast binary stages ahead of the divider
    localparam int DIV2_W   = 1;   // Single divide-by-two flip-flop
    localparam int NIB_W    = 4;   // 4-bit counter stage
    localparam int A_TOP_W  = 16;  // Channel A final counter
    localparam int B_TOP_W  = 12;  // Channel B final counter, physical width
    localparam int B_USE_W  = 11;  // Channel B final counter, bits in use
    localparam int A_W      = 29;  // Channel A hardwired width
    localparam int B_W      = 24;  // Channel B hardwired width

    // ==========================================================
    // Readout chain
    // ==========================================================
    localparam int SR_COUNT = 5;   // Cascaded parallel-to-serial registers
    localparam int SR_W     = 11;  // Width of one register
    localparam int CHAIN_W  = 55;  // Total chain length

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int SYNC_STAGES = 2;

    // Reset values
    localparam logic [A_W-1:0]     A_RST    = 29'h0;
    localparam logic [B_TOP_W-1:0] BTOP_RST = 12'h0;
    localparam logic [FAST_W-1:0]  FAST_RST = 8'h0;

    // Pins arriving from outside the clock domain
    typedef struct packed {
        logic chan_a;        // Channel A event input
        logic chan_b;        // Channel B event / time-base input
        logic gate_n;        // Measurement gate, low opens
        logic load;          // readout_load_control
        logic sclk;          // Serial shift clock
        logic sdin;          // Serial cascade input
        logic master_clear;  // Clears both accumulators
    } dac_pins_type;

    // Device answers
    typedef struct packed {
        logic sdout;         // Serial readout data
        logic meas_done_n;   // Measurement complete, active low
    } dac_outs_type;

endpackage

//--- dac_shift_stage.sv
`timescale 1ns/1ps
// ==============================================================
// One parallel-to-serial readout register
// ==============================================================
module dac_shift_stage #(
    parameter int W = 11
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic         shift,
    input  wire logic [W-1:0] par_in,
    input  wire logic         ser_in,
    output logic              ser_out
);
    import dac_pkg::*;

    logic [W-1:0] sr_q;

    // Refuse a register too short to shift
    if (W < 2) begin : g_bad_width
        $error("dac_shift_stage: W must be at least 2");
    end

    // Copy while loading, else shift toward bit 0 on each clock edge with shift high
    always_ff @(posedge mclk) begin
        if (rst) begin
            sr_q <= '0;
        end else if (load) begin
            sr_q <= par_in;
        end else if (shift) begin
            sr_q <= {ser_in, sr_q[W-1:1]};
        end
    end

    assign ser_out = sr_q[0];
endmodule

//--- dac_count_chain.sv
`timescale 1ns/1ps
module dac_count_chain #(
    parameter int NSTAGE = 5,
    parameter int STW    = 11
) (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire dac_pkg::dac_pins_type pins,
    output dac_pkg::dac_outs_type      outs
);
    import dac_pkg::*;

    // Refuse parameter sets that the chain cannot serve
    if (NSTAGE * STW < A_W + B_W) begin : g_short_chain
        $error("dac_count_chain: readout chain shorter than counts");
    end
    if (FAST_W + DIV2_W + NIB_W + A_TOP_W != A_W) begin : g_a_width
        $error("dac_count_chain: channel A segments mismatch");
    end
    if (FAST_W + DIV2_W + NIB_W + B_USE_W != B_W) begin : g_b_width
        $error("dac_count_chain: channel B segments mismatch");
    end

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    dac_pins_type meta_q;
    dac_pins_type sync_q;
    logic         a_last_q;
    logic         b_last_q;
    logic         sclk_last_q;

    // Two flops on every pin; only the second is read by logic
    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
        end
    end

    // Edge history of the synchronised pins
    always_ff @(posedge mclk) begin
        if (rst) begin
            a_last_q    <= 1'b0;
            b_last_q    <= 1'b0;
            sclk_last_q <= 1'b0;
        end else begin
            a_last_q    <= sync_q.chan_a;
            b_last_q    <= sync_q.chan_b;
            sclk_last_q <= sync_q.sclk;
        end
    end

    logic a_evt;
    logic b_evt;
    logic sclk_rise;
    logic clr;

    assign a_evt     = sync_q.chan_a & ~a_last_q;
    assign b_evt     = sync_q.chan_b & ~b_last_q;
    assign sclk_rise = sync_q.sclk & ~sclk_last_q;
    assign clr       = sync_q.master_clear;

    // ==========================================================
    // Gate synchronisers
    // ==========================================================
    logic gate_a_q;   // High keeps channel A gating closed
    logic gate_b_q;   // High keeps channel B gating closed
    logic armed_q;    // A measurement has opened the gate

    // First follows the gate on channel A edges, second follows the first on B edges
    always_ff @(posedge mclk) begin
        if (rst || clr) begin
            gate_a_q <= 1'b1;
            gate_b_q <= 1'b1;
        end else begin
            if (a_evt) begin
                gate_a_q <= sync_q.gate_n;
            end
            if (b_evt) begin
                gate_b_q <= gate_a_q;
            end
        end
    end

    // Remember that a measurement ran, so done only follows one
    always_ff @(posedge mclk) begin
        if (rst || clr) begin
            armed_q <= 1'b0;
        end else if (!gate_a_q) begin
            armed_q <= 1'b1;
        end
    end

    logic done_n_q;

    // Done falls once both synchronisers have shut off counting
    always_ff @(posedge mclk) begin
        if (rst || clr) begin
            done_n_q <= 1'b1;
        end else begin
            done_n_q <= ~(armed_q & gate_a_q & gate_b_q);
        end
    end

    // ==========================================================
    // Accumulators
    // ==========================================================
    logic [FAST_W-1:0]  a_fast_q;
    logic [FAST_W-1:0]  b_fast_q;
    logic               a_div_q;
    logic               b_div_q;
    logic [NIB_W-1:0]   a_nib_q;
    logic [NIB_W-1:0]   b_nib_q;
    logic [A_TOP_W-1:0] a_top_q;
    logic [B_TOP_W-1:0] b_top_q;

    logic a_cnt;
    logic b_cnt;
    logic a_c0;
    logic a_c1;
    logic a_c2;
    logic b_c0;
    logic b_c1;
    logic b_c2;

    assign a_cnt = a_evt & ~gate_a_q;
    assign b_cnt = b_evt & ~gate_b_q;

    // Carry from each segment clocks the next, as in a ripple chain
    assign a_c0 = a_cnt & (&a_fast_q);
    assign a_c1 = a_c0 & a_div_q;
    assign a_c2 = a_c1 & (&a_nib_q);
    assign b_c0 = b_cnt & (&b_fast_q);
    assign b_c1 = b_c0 & b_div_q;
    assign b_c2 = b_c1 & (&b_nib_q);

    // Channel A segments
    always_ff @(posedge mclk) begin
        if (rst || clr) begin
            a_fast_q <= FAST_RST;
            a_div_q  <= 1'b0;
            a_nib_q  <= '0;
            a_top_q  <= '0;
        end else begin
            if (a_cnt) a_fast_q <= a_fast_q + 1'b1;
            if (a_c0)  a_div_q  <= ~a_div_q;
            if (a_c1)  a_nib_q  <= a_nib_q + 1'b1;
            if (a_c2)  a_top_q  <= a_top_q + 1'b1;
        end
    end

    // Channel B segments
    always_ff @(posedge mclk) begin
        if (rst || clr) begin
            b_fast_q <= FAST_RST;
            b_div_q  <= 1'b0;
            b_nib_q  <= '0;
            b_top_q  <= BTOP_RST;
        end else begin
            if (b_cnt) b_fast_q <= b_fast_q + 1'b1;
            if (b_c0)  b_div_q  <= ~b_div_q;
            if (b_c1)  b_nib_q  <= b_nib_q + 1'b1;
            if (b_c2)  b_top_q  <= b_top_q + 1'b1;
        end
    end

    logic [A_W-1:0] a_val;
    logic [B_W-1:0] b_val;

    // Hardwired views; channel B drops its top counter bit
    assign a_val = {a_top_q, a_nib_q, a_div_q, a_fast_q};
    assign b_val = {b_top_q[B_USE_W-1:0], b_nib_q, b_div_q, b_fast_q};

    // ==========================================================
    // Readout cascade
    // ==========================================================
    localparam int TOTAL = NSTAGE * STW;

    logic [TOTAL-1:0]  par_all;
    logic [NSTAGE:0]   link;

    // Channel A LSB leaves first, then channel B LSB upward
    assign par_all = {{(TOTAL - A_W - B_W){1'b0}}, b_val, a_val};
    assign link[NSTAGE] = sync_q.sdin;

    genvar g;
    generate
        for (g = 0; g < NSTAGE; g++) begin : g_sr
            dac_shift_stage #(
                .W       (STW)
            ) u_stage (
                .mclk    (mclk),
                .rst     (rst),
                .load    (sync_q.load),
                .shift   (sclk_rise),
                .par_in  (par_all[g*STW +: STW]),
                .ser_in  (link[g+1]),
                .ser_out (link[g])
            );
        end
    endgenerate

    logic sdout_q;

    // Serial output from a flop
    always_ff @(posedge mclk) begin
        if (rst) begin
            sdout_q <= 1'b0;
        end else begin
            sdout_q <= link[0];
        end
    end

    assign outs.sdout       = sdout_q;
    assign outs.meas_done_n = done_n_q;
endmodule

//--- dac_chain_props.sv
`timescale 1ns/1ps
module dac_chain_props #(
    parameter int NSTAGE = 5,
    parameter int STW    = 11
) (
    input wire logic                  mclk,
    input wire logic                  rst,
    input wire dac_pkg::dac_pins_type pins,
    input wire dac_pkg::dac_outs_type outs
);
    import dac_pkg::*;
    logic       sclk_q;
    logic [3:0] quiet_q;

    // ==========================================
    // Cycles since the last load or clock rise
    // ==========================================
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Raw serial clock history
    always_ff @(posedge mclk) begin
        sclk_q <= pins.sclk;
    end
    // Saturating quiet counter
    always_ff @(posedge mclk) begin
        if (rst || pins.load || (pins.sclk && !sclk_q)) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hf) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end

    // ==========================================
    // Properties
    // ==========================================
    rst_idle_a: assert property (disable iff (1'b0) rst |=>
        !outs.sdout && outs.meas_done_n) else $error("reset idle wrong");
    clr_done_a: assert property (pins.master_clear[*3] |=>
        outs.meas_done_n) else $error("done low under clear");
    clr_zero_a: assert property ((pins.load && pins.master_clear)[*8]
        |-> !outs.sdout) else $error("count not cleared");
    load_hold_a: assert property ((pins.load && $stable(pins.chan_a)
        && $stable(pins.master_clear))[*8] |-> $stable(outs.sdout))
        else $error("copy changed without event");
    shift_idle_a: assert property ((!pins.load && !pins.sclk)[*8]
        |-> $stable(outs.sdout)) else $error("shift without clock");
    sdout_cause_a: assert property ($changed(outs.sdout)
        |-> quiet_q < 4'h8) else $error("sdout moved with no cause");
    done_gate_a: assert property ($fell(outs.meas_done_n)
        |-> $past(pins.gate_n, 4)) else $error("done with gate open");
    done_held_a: assert property (!outs.meas_done_n &&
        !pins.master_clear |=> !outs.meas_done_n) else $error("done lost");
endmodule

bind dac_count_chain dac_chain_props #(.NSTAGE(NSTAGE), .STW(STW)) chk_u (
    .mclk(mclk), .rst(rst), .pins(pins), .outs(outs));

//--- dac_proc_model.sv
`timescale 1ns/1ps
module dac_proc_model (
    input  wire logic mclk,
    input  wire logic sdout,
    output logic      load,
    output logic      sclk,
    output logic      gate_n,
    output logic      mclr
);
    logic [13:0] ext_a;   // Firmware upper bits, channel A
    logic [18:0] ext_b;   // Firmware upper bits, channel B
    logic [28:0] last_a;  // Previous hardwired reading, channel A
    logic [23:0] last_b;  // Previous hardwired reading, channel B

    // Idle: serial clock still, gate closed
    initial begin
        load = 1'b0;
        sclk = 1'b0;
        gate_n = 1'b1;
        mclr = 1'b0;
    end
    // Clear both accumulators before a measurement
    task automatic clear();
        @(negedge mclk);
        mclr = 1'b1;
        load = 1'b1;
        ext_a = '0;
        ext_b = '0;
        last_a = '0;
        last_b = '0;
        repeat (10) @(negedge mclk);
        mclr = 1'b0;
        load = 1'b0;
        repeat (4) @(negedge mclk);
    endtask
    // Open or close the measurement gate
    task automatic gate(input logic v);
        @(negedge mclk);
        gate_n = v;
        repeat (4) @(negedge mclk);
    endtask
    // Capture, then shift the chain out, hp cycles per half period
    task automatic readout(input int hp, output logic [54:0] v);
        @(negedge mclk);
        load = 1'b1;
        repeat (6) @(negedge mclk);
        load = 1'b0;
        repeat (hp) @(negedge mclk);
        for (int i = 0; i < 55; i++) begin
            v[i] = sdout;
            sclk = 1'b1;
            repeat (hp) @(negedge mclk);
            sclk = 1'b0;
            repeat (hp) @(negedge mclk);
        end
    endtask
    // Extend both channels to 43 bits; a drop in the low bits is a wrap
    task automatic extend(input logic [54:0] v, output logic [42:0] fa,
                          output logic [42:0] fb);
        if (v[28:0] < last_a) ext_a = ext_a + 14'h1;
        if (v[52:29] < last_b) ext_b = ext_b + 19'h1;
        last_a = v[28:0];
        last_b = v[52:29];
        fa = {ext_a, v[28:0]};
        fb = {ext_b, v[52:29]};
    endtask
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import dac_pkg::*;
    logic         mclk, rst, chan_a, chan_b, sdin, load, sclk, gate_n, mclr;
    dac_pins_type pins;
    dac_outs_type outs;
    int           seed, r, n_fail, checked, ma, mb, ao, bo, k;

    assign pins = '{chan_a, chan_b, gate_n, load, sclk, sdin, mclr};
    always #5 mclk = ~mclk;
    dac_count_chain #(.NSTAGE(SR_COUNT), .STW(SR_W)) dut_u (
        .mclk(mclk), .rst(rst), .pins(pins), .outs(outs));
    dac_proc_model proc_u (.mclk(mclk), .sdout(outs.sdout), .load(load),
        .sclk(sclk), .gate_n(gate_n), .mclr(mclr));

    // ==========================================
    // Checking and verdict
    // ==========================================
    task automatic cmp(input string nm, input logic [31:0] e, got);
        checked++;
        if (got !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, got);
        end
    endtask
    task automatic give_verdict();
        if (n_fail == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // One event pulse, 2 high and 2 low; model the gates alongside
    task automatic ev(input bit a, input bit b);
        @(negedge mclk);
        chan_a = a;
        chan_b = b;
        sdin = r[2];
        repeat (2) @(negedge mclk);
        chan_a = 1'b0;
        chan_b = 1'b0;
        @(negedge mclk);
        // An edge counts if its gate was open; B takes A's old state
        if (b) begin
            if (bo) mb++;
            bo = ao;
        end
        if (a) begin
            if (ao) ma++;
            ao = !gate_n;
        end
    endtask
    // Read the chain and compare both channels
    task automatic read_cmp(input int hp);
        logic [54:0] v;
        logic [42:0] fa;
        logic [42:0] fb;
        proc_u.readout(hp, v);
        proc_u.extend(v, fa, fb);
        cmp("chan_a_count", ma & 32'h1fffffff, {3'h0, v[28:0]});
        cmp("chan_b_count", mb & 32'hffffff, {8'h0, v[52:29]});
        cmp("chain_pad", 32'h0, {30'h0, v[54:53]});
        cmp("chan_a_total", ma, fa[31:0]);
        cmp("chan_a_upper", 32'h0, {21'h0, fa[42:32]});
        cmp("chan_b_total", mb, fb[31:0]);
        cmp("chan_b_upper", 32'h0, {21'h0, fb[42:32]});
    endtask

    // ==========================================
    // Main sequence
    // ==========================================
    initial begin
        seed = 32'hfa6762ba;
        {mclk, chan_a, chan_b, sdin, r, n_fail, checked} = '0;
        rst = 1'b1;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        for (int m = 0; m < 2; m++) begin
            proc_u.clear();
            {ma, mb, ao, bo} = '0;
            repeat (3) ev(1'b1, 1'b1);
            proc_u.gate(1'b0);
            ev(1'b1, 1'b0);
            ev(1'b0, 1'b1);
            for (int i = 0; i < (m ? 300 : 10000); i++) begin
                r = $random(seed);
                ev(r[0], r[1] | !r[0]);
            end
            read_cmp(8);
            cmp("meas_done_n", 32'h1, {31'h0, outs.meas_done_n});
            proc_u.gate(1'b1);
            ev(1'b1, 1'b0);
            ev(1'b0, 1'b1);
            for (k = 0; k < 50 && outs.meas_done_n !== 1'b0; k++) begin
                @(negedge mclk);
            end
            cmp("meas_done_n", 32'h0, {31'h0, outs.meas_done_n});
            if (k == 50) begin
                give_verdict();
            end
            read_cmp(8);
        end
        give_verdict();
    end
endmodule
